// [rtl/pmlq_pkg.sv]
// Shared constants and types of the power mode and link quality registers
package pmlq_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [15:0] AUTO_SLEEP_OFS = 16'h018b;
  localparam logic [15:0] PWR_CMD_OFS    = 16'h018c;
  localparam logic [15:0] NOISE_OFS      = 16'h0197;
  localparam logic [15:0] QUALITY_OFS    = 16'h0198;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int AUTO_BIT        = 6;
  localparam int SLEEP_SEL_BIT   = 1;
  localparam int LPS_EN_BIT      = 0;
  localparam int RSV_LO_LSB      = 2;
  localparam int RSV_LO_MSB      = 5;
  localparam int RSV_HI_LSB      = 7;
  localparam int SLEEP_REQ_BIT   = 1;
  localparam int FORCE_NORM_BIT  = 0;
  localparam int PWR_RSV_LSB     = 2;
  localparam int NOISE_MSB       = 8;
  localparam int CLASS_LSB       = 8;
  localparam int CLASS_MSB       = 9;
  localparam int INDEX_MSB       = 7;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic       SLEEP_SEL_RST  = 1'h1;
  localparam logic       LPS_EN_RST     = 1'h0;
  localparam logic [3:0] RSV_LO_RST     = 4'h6;
  localparam logic [8:0] RSV_HI_RST     = 9'h000;
  localparam logic       SLEEP_REQ_RST  = 1'h0;
  localparam logic       FORCE_NORM_RST = 1'h0;
  localparam logic [13:0] PWR_RSV_RST   = 14'h0000;
  localparam logic [15:0] RDATA_RST     = 16'h0000;

  // ************************************************************
  // Quality bands: above 70 excellent, 40 up to 70 good
  // ************************************************************
  localparam logic [7:0] INDEX_EXCELLENT_ABOVE = 8'h46;
  localparam logic [7:0] INDEX_GOOD_MIN        = 8'h28;

  typedef enum logic [1:0] {
    CLS_NO_LINK   = 2'b00,
    CLS_POOR      = 2'b01,
    CLS_GOOD      = 2'b10,
    CLS_EXCELLENT = 2'b11
  } pmlq_class_t;

  typedef enum logic [1:0] {
    PST_NORMAL  = 2'b00,
    PST_LPS_TX  = 2'b01,
    PST_SLEEP   = 2'b10,
    PST_STANDBY = 2'b11
  } pmlq_pstate_t;

endpackage

// [rtl/pmlq_power_fsm.sv]
// Power state machine: Normal, sleep request, Sleep and Standby
`timescale 1ns/1ps
`default_nettype none
module pmlq_power_fsm
  import pmlq_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic             sleep_req,
  input  wire logic             lps_en_next,
  input  wire logic             sleep_sel,
  input  wire logic             force_normal,
  input  wire logic             neg_done,
  input  wire logic             wake_req,
  output logic                  standby_exit,
  output pmlq_pkg::pmlq_pstate_t state_q,
  output logic                  send_code_q
);

  pmlq_pstate_t state_d;
  logic         send_code_d;

  // Next state; forcing Normal beats every other move
  always_comb begin
    state_d      = state_q;
    standby_exit = 1'b0;
    case (state_q)
      PST_NORMAL: begin
        if (sleep_req && !force_normal) begin
          state_d = PST_LPS_TX;
        end
      end
      PST_LPS_TX: begin
        if (force_normal || !sleep_req) begin
          state_d = PST_NORMAL;
        end else if (neg_done && send_code_q) begin
          state_d = sleep_sel ? PST_SLEEP : PST_STANDBY;
        end
      end
      PST_SLEEP: begin
        if (force_normal || wake_req) begin
          state_d = PST_NORMAL;
        end
      end
      PST_STANDBY: begin
        if (force_normal || wake_req) begin
          state_d      = PST_NORMAL;
          standby_exit = 1'b1;
        end
      end
      default: begin
        state_d = PST_NORMAL;
      end
    endcase
    // Uses the next enable value so a cleared bit stops codes at once
    send_code_d = (state_d == PST_LPS_TX) && lps_en_next;
  end

  // State registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= PST_NORMAL;
      send_code_q <= 1'b0;
    end else if (clk_en) begin
      state_q     <= state_d;
      send_code_q <= send_code_d;
    end
  end

endmodule
`default_nettype wire

// [rtl/pmlq_quality.sv]
// Noise ratio and quality index capture with class derivation
`timescale 1ns/1ps
`default_nettype none
module pmlq_quality
  import pmlq_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic            clk_en,
  input  wire logic            link_up,
  input  wire logic            meas_valid,
  input  wire logic [8:0]      meas_snr,
  input  wire logic [7:0]      meas_sqi,
  output logic [8:0]           noise_q,
  output logic [7:0]           index_q,
  output pmlq_pkg::pmlq_class_t class_q
);

  logic [8:0]  noise_d;
  logic [7:0]  index_d;
  pmlq_class_t class_d;

  // Class comes from the very sample that loads the index
  always_comb begin
    noise_d = noise_q;
    index_d = index_q;
    class_d = class_q;
    if (!link_up) begin
      index_d = 8'h00;
      class_d = CLS_NO_LINK;
    end else if (meas_valid) begin
      noise_d = meas_snr;
      index_d = meas_sqi;
      if (meas_sqi > INDEX_EXCELLENT_ABOVE) begin
        class_d = CLS_EXCELLENT;
      end else if (meas_sqi >= INDEX_GOOD_MIN) begin
        class_d = CLS_GOOD;
      end else begin
        class_d = CLS_POOR;
      end
    end
  end

  // Result registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      noise_q <= 9'h000;
      index_q <= 8'h00;
      class_q <= CLS_NO_LINK;
    end else if (clk_en) begin
      noise_q <= noise_d;
      index_q <= index_d;
      class_q <= class_d;
    end
  end

endmodule
`default_nettype wire

// [rtl/pmlq_regs.sv]
// Power mode and link quality register bank with strap capture
//
// Function
// - Autonomy bit loads from the strap
// - Autonomy bit reads zero after first access
// - Managed mode only from strap, caught after reset release
// - After negotiation: Sleep if selected, else Standby
// - Sleep codes sent only while permitted
// - Sleep request bit starts sleep code transmission
// - Force-normal bit forces the Normal state
// - Force-normal self-clears only on Standby to Normal; a write of zero also clears it
// - Noise field holds ten times NOISE_RATIO_RESULT in dB
// - Class field encodes link quality band
// - Index thresholds: above 70, 40 to 70
// - Class and index come from one sample
`timescale 1ns/1ps
`default_nettype none
module pmlq_regs
  import pmlq_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic              strap_autonomous,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [15:0]            reg_rdata,
  input  wire logic              link_up,
  input  wire logic              neg_done,
  input  wire logic              wake_req,
  input  wire logic              meas_valid,
  input  wire logic [8:0]        meas_snr,
  input  wire logic [7:0]        meas_sqi,
  output logic                   managed_mode,
  output pmlq_pkg::pmlq_pstate_t power_state,
  output logic                   send_sleep_code
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // The highest offset needs nine address bits
  if (ADDR_W < 9 || ADDR_W > 16) begin : g_addr_chk
    $error("pmlq_regs: ADDR_W must lie between 9 and 16");
  end

  // ************************************************************
  // Address decode
  // ************************************************************
  logic [15:0] addr_full;
  logic        hit_auto;
  logic        hit_pwr;
  logic        hit_noise;
  logic        hit_quality;
  logic        wr_auto;
  logic        wr_pwr;
  logic        acc_auto;

  // Upper address bits beyond the port width read as zero
  always_comb begin
    addr_full              = 16'h0000;
    addr_full[ADDR_W-1:0]  = reg_addr;
    hit_auto    = (addr_full == AUTO_SLEEP_OFS);
    hit_pwr     = (addr_full == PWR_CMD_OFS);
    hit_noise   = (addr_full == NOISE_OFS);
    hit_quality = (addr_full == QUALITY_OFS);
    wr_auto     = reg_wr && hit_auto;
    wr_pwr      = reg_wr && hit_pwr;
    acc_auto    = (reg_wr || reg_rd) && hit_auto;
  end

  // ************************************************************
  // Strap capture and autonomy bit
  // ************************************************************
  logic strap_taken_q;
  logic strap_taken_d;
  logic auto_q;
  logic auto_d;
  logic auto_used_q;
  logic auto_used_d;
  logic managed_q;
  logic managed_d;

  // The strap is caught at the first enabled edge after release,
  // never by the reset itself; later writes cannot alter the mode
  always_comb begin
    strap_taken_d = strap_taken_q;
    auto_d        = auto_q;
    managed_d     = managed_q;
    auto_used_d   = auto_used_q;
    if (!strap_taken_q) begin
      strap_taken_d = 1'b1;
      auto_d        = strap_autonomous;
      managed_d     = !strap_autonomous;
    end
    if (acc_auto) begin
      auto_used_d = 1'b1;
    end
  end

  // Strap registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_taken_q <= 1'b0;
      auto_q        <= 1'b0;
      auto_used_q   <= 1'b0;
      managed_q     <= 1'b0;
    end else if (clk_en) begin
      strap_taken_q <= strap_taken_d;
      auto_q        <= auto_d;
      auto_used_q   <= auto_used_d;
      managed_q     <= managed_d;
    end
  end

  assign managed_mode = managed_q;

  // ************************************************************
  // Autonomy and sleep control register
  // ************************************************************
  logic       sleep_sel_q;
  logic       sleep_sel_d;
  logic       lps_en_q;
  logic       lps_en_d;
  logic [3:0] rsv_lo_q;
  logic [3:0] rsv_lo_d;
  logic [8:0] rsv_hi_q;
  logic [8:0] rsv_hi_d;

  // Plain read/write fields; the autonomy bit has no storage here
  always_comb begin
    sleep_sel_d = sleep_sel_q;
    lps_en_d    = lps_en_q;
    rsv_lo_d    = rsv_lo_q;
    rsv_hi_d    = rsv_hi_q;
    if (wr_auto) begin
      sleep_sel_d = reg_wdata[SLEEP_SEL_BIT];
      lps_en_d    = reg_wdata[LPS_EN_BIT];
      rsv_lo_d    = reg_wdata[RSV_LO_MSB:RSV_LO_LSB];
      rsv_hi_d    = reg_wdata[15:RSV_HI_LSB];
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_sel_q <= SLEEP_SEL_RST;
      lps_en_q    <= LPS_EN_RST;
      rsv_lo_q    <= RSV_LO_RST;
      rsv_hi_q    <= RSV_HI_RST;
    end else if (clk_en) begin
      sleep_sel_q <= sleep_sel_d;
      lps_en_q    <= lps_en_d;
      rsv_lo_q    <= rsv_lo_d;
      rsv_hi_q    <= rsv_hi_d;
    end
  end

  // ************************************************************
  // Power state command register
  // ************************************************************
  logic        sleep_req_q;
  logic        sleep_req_d;
  logic        force_norm_q;
  logic        force_norm_d;
  logic [13:0] pwr_rsv_q;
  logic [13:0] pwr_rsv_d;
  logic        standby_exit;

  // A write of one that meets the self-clear wins over the clear,
  // so a fresh force request is never lost
  always_comb begin
    sleep_req_d  = sleep_req_q;
    force_norm_d = force_norm_q;
    pwr_rsv_d    = pwr_rsv_q;
    if (standby_exit) begin
      force_norm_d = 1'b0;
    end
    if (wr_pwr) begin
      sleep_req_d = reg_wdata[SLEEP_REQ_BIT];
      pwr_rsv_d   = reg_wdata[15:PWR_RSV_LSB];
      if (reg_wdata[FORCE_NORM_BIT]) begin
        force_norm_d = 1'b1;
      end else if (!standby_exit) begin
        force_norm_d = 1'b0;
      end
    end
  end

  // Command registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_req_q  <= SLEEP_REQ_RST;
      force_norm_q <= FORCE_NORM_RST;
      pwr_rsv_q    <= PWR_RSV_RST;
    end else if (clk_en) begin
      sleep_req_q  <= sleep_req_d;
      force_norm_q <= force_norm_d;
      pwr_rsv_q    <= pwr_rsv_d;
    end
  end

  // ************************************************************
  // Power state machine
  // ************************************************************
  // Negotiation completes only while codes are on the line
  pmlq_power_fsm u_power_fsm (
    .clk          (clk),
    .reset_n      (reset_n),
    .clk_en       (clk_en),
    .sleep_req    (sleep_req_q),
    .lps_en_next  (lps_en_d),
    .sleep_sel    (sleep_sel_q),
    .force_normal (force_norm_q),
    .neg_done     (neg_done),
    .wake_req     (wake_req),
    .standby_exit (standby_exit),
    .state_q      (power_state),
    .send_code_q  (send_sleep_code)
  );

  // ************************************************************
  // Measurement results
  // ************************************************************
  logic [8:0]  noise_val;
  logic [7:0]  index_val;
  pmlq_class_t class_val;

  // Both results are read-only; the bus never reaches them
  pmlq_quality u_quality (
    .clk        (clk),
    .reset_n    (reset_n),
    .clk_en     (clk_en),
    .link_up    (link_up),
    .meas_valid (meas_valid),
    .meas_snr   (meas_snr),
    .meas_sqi   (meas_sqi),
    .noise_q    (noise_val),
    .index_q    (index_val),
    .class_q    (class_val)
  );

  // ************************************************************
  // Read path
  // ************************************************************
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;

  // Data stand only in the cycle after the read strobe; unmapped
  // offsets and reserved result bits read zero
  always_comb begin
    rdata_d = RDATA_RST;
    if (reg_rd) begin
      if (hit_auto) begin
        rdata_d[15:RSV_HI_LSB]         = rsv_hi_q;
        rdata_d[AUTO_BIT]              = auto_q && !auto_used_q;
        rdata_d[RSV_LO_MSB:RSV_LO_LSB] = rsv_lo_q;
        rdata_d[SLEEP_SEL_BIT]         = sleep_sel_q;
        rdata_d[LPS_EN_BIT]            = lps_en_q;
      end else if (hit_pwr) begin
        rdata_d[15:PWR_RSV_LSB]   = pwr_rsv_q;
        rdata_d[SLEEP_REQ_BIT]    = sleep_req_q;
        rdata_d[FORCE_NORM_BIT]   = force_norm_q;
      end else if (hit_noise) begin
        rdata_d[NOISE_MSB:0]      = noise_val;
      end else if (hit_quality) begin
        rdata_d[CLASS_MSB:CLASS_LSB] = class_val;
        rdata_d[INDEX_MSB:0]         = index_val;
      end
    end
  end

  // Read data register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= RDATA_RST;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule
`default_nettype wire

// [bench/pmlq_checker.sv]
// Checker of the power mode and link quality register bank
`timescale 1ns/1ps
`default_nettype none
module pmlq_checker
  import pmlq_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic                   clk_en,
  input wire logic                   strap_autonomous,
  input wire logic [ADDR_W-1:0]      reg_addr,
  input wire logic [15:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [15:0]            reg_rdata,
  input wire logic                   link_up,
  input wire logic                   neg_done,
  input wire logic                   wake_req,
  input wire logic                   meas_valid,
  input wire logic [8:0]             meas_snr,
  input wire logic [7:0]             meas_sqi,
  input wire logic                   managed_mode,
  input wire pmlq_pkg::pmlq_pstate_t power_state,
  input wire logic                   send_sleep_code
);
  import pmlq_pkg::*;
  // ************************************************************
  // Shadows of the control bits, rebuilt from bus traffic
  // ************************************************************
  logic [15:0] a16;
  logic        acc;
  logic        sel_d, sel_q, perm_d, perm_q, seen_d, seen_q;
  logic [1:0]  up_d, up_q;
  assign a16 = 16'(reg_addr);
  assign acc = clk_en && a16 == AUTO_SLEEP_OFS;
  // Counter waits past the strap capture edge before trusting it
  always_comb begin
    sel_d  = sel_q;
    perm_d = perm_q;
    seen_d = seen_q;
    up_d   = up_q;
    if (clk_en && up_q != 2'h2) up_d = up_q + 2'h1;
    if (acc && (reg_wr || reg_rd)) seen_d = 1'b1;
    if (acc && reg_wr) begin
      sel_d  = reg_wdata[SLEEP_SEL_BIT];
      perm_d = reg_wdata[LPS_EN_BIT];
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q  <= SLEEP_SEL_RST;
      perm_q <= LPS_EN_RST;
      seen_q <= 1'b0;
      up_q   <= 2'h0;
    end else begin
      sel_q  <= sel_d;
      perm_q <= perm_d;
      seen_q <= seen_d;
      up_q   <= up_d;
    end
  end
  // Quality band of an index while the link is up
  function automatic logic [1:0] band(input logic [7:0] idx);
    if (idx > INDEX_EXCELLENT_ABOVE) return CLS_EXCELLENT;
    if (idx >= INDEX_GOOD_MIN) return CLS_GOOD;
    return CLS_POOR;
  endfunction
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd(logic [15:0] ofs);
    reg_rd && clk_en && a16 == ofs;
  endsequence
  sequence s_req;
    reg_wr && clk_en && a16 == PWR_CMD_OFS && reg_wdata[1:0] == 2'h2
      && power_state == PST_NORMAL;
  endsequence
  sequence s_force;
    reg_wr && clk_en && a16 == PWR_CMD_OFS && reg_wdata[FORCE_NORM_BIT]
      && power_state inside {PST_SLEEP, PST_STANDBY};
  endsequence
  property p_auto_strap;
    s_rd(AUTO_SLEEP_OFS) ##0 (!seen_q && up_q == 2'h2)
      |=> reg_rdata[AUTO_BIT] == !managed_mode;
  endproperty
  a_auto_strap: assert property (p_auto_strap) else $error("auto bit");
  property p_auto_once;
    s_rd(AUTO_SLEEP_OFS) ##0 seen_q |=> reg_rdata[AUTO_BIT] == 1'b0;
  endproperty
  a_auto_once: assert property (p_auto_once) else $error("auto once");
  property p_managed;
    up_q == 2'h2 |-> $stable(managed_mode);
  endproperty
  a_managed: assert property (p_managed) else $error("managed moved");
  property p_lowpower;
    power_state == PST_LPS_TX && send_sleep_code && neg_done && clk_en
      && !reg_wr && !wake_req
      |=> power_state == (sel_q ? PST_SLEEP : PST_STANDBY);
  endproperty
  a_lowpower: assert property (p_lowpower) else $error("low state");
  property p_send;
    send_sleep_code |-> perm_q && power_state == PST_LPS_TX;
  endproperty
  a_send: assert property (p_send) else $error("codes unpermitted");
  property p_req;
    s_req ##1 (!reg_wr && !wake_req && clk_en)
      |=> power_state == PST_LPS_TX && send_sleep_code == perm_q;
  endproperty
  a_req: assert property (p_req) else $error("sleep request");
  property p_force;
    s_force ##1 (!reg_wr && clk_en) |=> power_state == PST_NORMAL;
  endproperty
  a_force: assert property (p_force) else $error("force normal");
  property p_noise;
    s_rd(NOISE_OFS) |=> reg_rdata[15:9] == 7'h00;
  endproperty
  a_noise: assert property (p_noise) else $error("noise spare");
  property p_class;
    s_rd(QUALITY_OFS) |=> reg_rdata[15:10] == 6'h00
      && (reg_rdata[9:8] == band(reg_rdata[7:0]) || reg_rdata[9:0] == 10'h000);
  endproperty
  a_class: assert property (p_class) else $error("class");
  property p_quiet;
    reg_rdata != 16'h0000 && $past(clk_en) |-> $past(reg_rd && clk_en);
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray data");
endmodule
bind pmlq_regs pmlq_checker #(.ADDR_W(ADDR_W)) i_chk (
  .clk(clk), .reset_n(reset_n), .clk_en(clk_en),
  .strap_autonomous(strap_autonomous), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .link_up(link_up), .neg_done(neg_done),
  .wake_req(wake_req), .meas_valid(meas_valid), .meas_snr(meas_snr),
  .meas_sqi(meas_sqi), .managed_mode(managed_mode),
  .power_state(power_state), .send_sleep_code(send_sleep_code)
);
`default_nettype wire

// [bench/pmlq_partner.sv]
// Remote link partner answering sleep request code-groups
`timescale 1ns/1ps
`default_nettype none
module pmlq_partner (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       send_sleep_code,
  input  wire logic [3:0] lag,
  input  wire logic       wake_cmd,
  output logic            neg_done,
  output logic            wake_req
);
  logic [3:0] wait_q;
  // One pulse each time the count meets lag, so every 17 cycles of a long burst; no stale answer leaks onward
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q   <= 4'h0;
      neg_done <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      neg_done <= 1'b0;
      wake_req <= wake_cmd;
      if (!send_sleep_code) wait_q <= 4'h0;
      else if (wait_q == lag && !neg_done) neg_done <= 1'b1;
      else wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// [bench/tb_power_mode_link_quality_regs.sv]
// Self-checking bench of the power mode and link quality registers
`timescale 1ns/1ps
`default_nettype none
module tb_power_mode_link_quality_regs;
  import pmlq_pkg::*;
  logic         clk = 1'b0;
  logic         reset_n, clk_en, strap, reg_wr, reg_rd, link_up;
  logic         neg_done, wake_req, meas_valid, managed_mode;
  logic         send_sleep_code, wake_cmd;
  logic [15:0]  reg_addr, reg_wdata, reg_rdata;
  logic [8:0]   meas_snr;
  logic [7:0]   meas_sqi;
  logic [3:0]   lag;
  pmlq_pstate_t power_state;
  int           bad_count, samples_checked;
  // Clock of 4 ns
  always #2 clk = ~clk;
  pmlq_regs #(.ADDR_W(16)) i_dut (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .strap_autonomous(strap), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link_up(link_up), .neg_done(neg_done),
    .wake_req(wake_req), .meas_valid(meas_valid), .meas_snr(meas_snr),
    .meas_sqi(meas_sqi), .managed_mode(managed_mode),
    .power_state(power_state), .send_sleep_code(send_sleep_code)
  );
  pmlq_partner i_partner (
    .clk(clk), .reset_n(reset_n), .send_sleep_code(send_sleep_code),
    .lag(lag), .wake_cmd(wake_cmd), .neg_done(neg_done),
    .wake_req(wake_req)
  );
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic conclude();
    $display("Checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus cycles leave an idle edge so a strobe is never set twice at once
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input string what, input logic [15:0] a,
                    input logic [15:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
    @(posedge clk);
  endtask
  task automatic wait_st(input pmlq_pstate_t s);
    #1;
    for (int i = 0; i < 40; i++) begin
      if (power_state === s) break;
      @(posedge clk);
      #1;
    end
    // Back onto the edge so later stimulus is launched there
    @(posedge clk);
  endtask
  task automatic do_reset(input logic s);
    strap   <= s;
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_strap(input logic s, input logic wr_first);
    do_reset(s);
    chk("managed", {15'h0000, ~s}, {15'h0000, managed_mode});
    if (wr_first) wr(AUTO_SLEEP_OFS, 16'h005a);
    rc("auto 1st", AUTO_SLEEP_OFS, {9'h000, s & ~wr_first, 6'h1a});
    rc("auto 2nd", AUTO_SLEEP_OFS, 16'h001a);
    wr(AUTO_SLEEP_OFS, {9'h000, ~s, 6'h1a});
    chk("mode kept", {15'h0000, ~s}, {15'h0000, managed_mode});
    rc("pwr reset", PWR_CMD_OFS, 16'h0000);
    rc("noise reset", NOISE_OFS, 16'h0000);
  endtask
  task automatic t_sleep(input logic sel, input logic [3:0] lg);
    lag <= lg;
    wr(AUTO_SLEEP_OFS, {14'h0006, sel, 1'b1});
    wr(PWR_CMD_OFS, 16'h0002);
    #1 chk("state req", 16'(PST_LPS_TX), 16'(power_state));
    chk("send on", 16'h0001, 16'(send_sleep_code));
    wait_st(sel ? PST_SLEEP : PST_STANDBY);
    chk("low state", {14'h0000, 1'b1, ~sel}, 16'(power_state));
    chk("send off", 16'h0000, 16'(send_sleep_code));
    if (sel) begin
      wake_cmd <= 1'b1;
      @(posedge clk);
      wake_cmd <= 1'b0;
      wait_st(PST_NORMAL);
      wait_st(PST_SLEEP);
      chk("re-sleep", 16'(PST_SLEEP), 16'(power_state));
    end
    wr(PWR_CMD_OFS, 16'h0001);
    rc("force bit", PWR_CMD_OFS, {15'h0000, sel});
    chk("forced", 16'(PST_NORMAL), 16'(power_state));
    wr(PWR_CMD_OFS, 16'h0000);
  endtask
  task automatic t_noperm();
    wr(AUTO_SLEEP_OFS, 16'h001a);
    wr(PWR_CMD_OFS, 16'h0002);
    repeat (8) begin
      #1 chk("no codes", 16'h0000, 16'(send_sleep_code));
      @(posedge clk);
    end
    #1 chk("held req", 16'(PST_LPS_TX), 16'(power_state));
    @(posedge clk);
    wr(PWR_CMD_OFS, 16'h0000);
    wait_st(PST_NORMAL);
    chk("req off", 16'(PST_NORMAL), 16'(power_state));
  endtask
  task automatic t_quality();
    logic [7:0] idx [6] = '{8'h47, 8'h46, 8'h28, 8'h27, 8'hff, 8'h00};
    logic [1:0] cls [6] = '{2'h3, 2'h2, 2'h2, 2'h1, 2'h3, 2'h1};
    link_up <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      meas_sqi   <= idx[i];
      meas_snr   <= {1'b1, idx[i]};
      meas_valid <= 1'b1;
      @(posedge clk);
      meas_valid <= 1'b0;
      @(posedge clk);
      rc("quality", QUALITY_OFS, {6'h00, cls[i], idx[i]});
      rc("noise", NOISE_OFS, {7'h00, 1'b1, idx[i]});
    end
    wr(QUALITY_OFS, 16'hffff);
    wr(NOISE_OFS, 16'hffff);
    wr(16'h0199, 16'hffff);
    rc("ro quality", QUALITY_OFS, 16'h0100);
    rc("ro noise", NOISE_OFS, 16'h0100);
    rc("unmapped", 16'h0199, 16'h0000);
    link_up    <= 1'b0;
    meas_valid <= 1'b1;
    @(posedge clk);
    meas_valid <= 1'b0;
    repeat (2) @(posedge clk);
    // Noise is left stale without link, so it is not judged here
    rc("no link", QUALITY_OFS, 16'h0000);
  endtask
  // A strobe seen while the enable is low must change nothing
  task automatic t_freeze();
    clk_en <= 1'b0;
    wr(PWR_CMD_OFS, 16'h0002);
    clk_en <= 1'b1;
    rc("frozen", PWR_CMD_OFS, 16'h0000);
  endtask
  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    reset_n         = 1'b0;
    clk_en          = 1'b1;
    strap           = 1'b1;
    reg_addr        = 16'h0000;
    reg_wdata       = 16'h0000;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    link_up         = 1'b0;
    meas_valid      = 1'b0;
    meas_snr        = 9'h000;
    meas_sqi        = 8'h00;
    wake_cmd        = 1'b0;
    lag             = 4'h0;
    bad_count       = 0;
    samples_checked = 0;
    t_strap(1'b1, 1'b0);
    t_strap(1'b1, 1'b1);
    t_strap(1'b0, 1'b0);
    t_sleep(1'b1, 4'h0);
    t_sleep(1'b0, 4'h7);
    t_noperm();
    t_quality();
    t_freeze();
    conclude();
  end
  // A hang counts as a mismatch; the whole run needs under 200 cycles
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
